// File: flash_seq_pkg.sv
// Shared constants and types of the program and erase sequencer.
// Functional notes
// R1: Quad page program runs only while quad_lines_enable is one.
// R2: Host sends 32h, three address bytes, data on four lines, select low.
// R3: Program and erase run only with write_enable_latch set.
// R4: Over 256 data bytes keep the last 256; untouched bytes stay unchanged.
// R5: Data past the page end wraps to the start of the same page.
// R6: Program runs only if select rises on a byte boundary of the data.
// R7: Host sends F2h, three address bytes and data on data_line_0.
// R8: Cycle starts at select rise; write_in_progress high; latch cleared before end.
// R9: Page program into a protected page is refused.
// R10: Opcode 20h erases the whole sector holding the address.
// R11: Erase runs only if select rises right after the last address byte.
// R12: Opcode 52h erases the whole 32KB block holding the address.
// R13: Opcode D8h erases the whole 64KB block holding the address.
// R14: Erase of a protected region is skipped.
// R15: Opcode C7h or 60h alone erases the whole array, busy until done.
// R16: Chip erase runs only when every protect bit is zero.
// R17: Opcode 75h pauses a running sector, block erase or page program.
// R18: During erase suspend, status write and erase commands are refused.
// R19: Suspend is ignored during chip erase.
// R20: During program suspend, status write and program commands are refused.
// R21: Resume 7Ah is taken only with suspend_flag one and write_in_progress zero.
// R22: Resume clears suspend_flag at once, busy within 200 ns, finishes the operation.
// R23: Host sends 02h, three address bytes and data on data_line_0.
// R24: While busy, new program and erase commands are rejected; suspend still served.
// R25: With the latch clear, program and erase leave contents and flags alone.
package flash_seq_pkg;
    localparam logic [7:0] OPC_PAGE = 8'h02;
    localparam logic [7:0] OPC_QUAD_PAGE = 8'h32;
    localparam logic [7:0] OPC_FAST_PAGE = 8'hf2;
    localparam logic [7:0] OPC_SECTOR = 8'h20;
    localparam logic [7:0] OPC_BLK32 = 8'h52;
    localparam logic [7:0] OPC_BLK64 = 8'hd8;
    localparam logic [7:0] OPC_CHIP_A = 8'hc7;
    localparam logic [7:0] OPC_CHIP_B = 8'h60;
    localparam logic [7:0] OPC_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7a;
    localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
    localparam logic [2:0] BYTES_CMD = 3'h1;
    localparam logic [2:0] BYTES_ADDR = 3'h4;
    localparam logic [2:0] BYTES_DATA = 3'h5;
    localparam logic [23:0] SECTOR_MASK = 24'hfff000;
    localparam logic [23:0] BLK32_MASK = 24'hff8000;
    localparam logic [23:0] BLK64_MASK = 24'hff0000;
    localparam int unsigned BLK64_LSB = 16;
    localparam logic [6:0] BLK64_COUNT = 7'h40;
    localparam int unsigned MCLK_MHZ = 40;
    localparam int unsigned RESUME_MAX_NS = 200;
    localparam int unsigned RESUME_MAX_CYC = RESUME_MAX_NS * MCLK_MHZ / 1000;

    typedef enum logic [2:0] {
        K_NONE = 3'h0, K_PAGE = 3'h1, K_SECTOR = 3'h2,
        K_BLK32 = 3'h3, K_BLK64 = 3'h4, K_CHIP = 3'h5
    } op_kind_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_BUSY = 3'h2, ST_HALT = 3'h4
    } seq_state_t;
    typedef struct packed {
        logic write_in_progress;
        logic write_enable_latch;
        logic suspend_flag;
    } flash_status_t;
    localparam flash_status_t STATUS_RST = 3'h0;
    typedef struct packed {
        op_kind_t kind;
        logic [23:0] addr;
        logic start;
        logic halt;
        logic resume;
        logic done;
    } mem_cmd_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [2:0] bytes;
        logic [2:0] bit_pos;
    } frame_cap_t;
    typedef struct packed {
        logic [7:0] data;
        logic keep;
    } pgm_byte_t;
endpackage : flash_seq_pkg

// File: nor_program_erase_sequencer.sv
// Serial command decoder and self-timed program and erase sequencer.
`timescale 1ns/100ps
module nor_program_erase_sequencer #(
    parameter int unsigned PROGRAM_CYCLE_TIME_US = 1000,
    parameter int unsigned SECTOR_ERASE_TIME_US = 100000,
    parameter int unsigned BLOCK_ERASE_TIME_US = 500000,
    parameter int unsigned CHIP_ERASE_TIME_US = 20000000
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_sclk,
    input wire logic i_select_n,
    input wire logic [3:0] i_data_line,
    input wire logic i_quad_lines_enable,
    input wire logic [4:0] i_protect,
    input wire logic [7:0] i_pgm_index,
    output flash_seq_pkg::flash_status_t o_status,
    output flash_seq_pkg::mem_cmd_t o_mem_cmd,
    output flash_seq_pkg::pgm_byte_t o_pgm_byte
);
    localparam logic [31:0] PP_CYC = 32'(PROGRAM_CYCLE_TIME_US * flash_seq_pkg::MCLK_MHZ);
    localparam logic [31:0] SE_CYC = 32'(SECTOR_ERASE_TIME_US * flash_seq_pkg::MCLK_MHZ);
    localparam logic [31:0] BE_CYC = 32'(BLOCK_ERASE_TIME_US * flash_seq_pkg::MCLK_MHZ);
    localparam logic [31:0] CE_CYC = 32'(CHIP_ERASE_TIME_US * flash_seq_pkg::MCLK_MHZ);

    // Link side: runs on serial clock edges inside a frame; only the fresh flag is also preset by select rising.
    logic fresh;
    logic frame_tog;
    logic [2:0] bpos;
    logic [2:0] bcnt;
    logic [7:0] shreg;
    logic [7:0] opc;
    logic [23:0] addr;
    logic [7:0] widx;
    logic lock_s1;
    logic lock_s2;
    logic [7:0] page_buf [256];
    logic [255:0] keep_mask;
    logic [2:0] cur_b;
    logic [2:0] cur_n;
    logic quad;
    logic [7:0] next_sh;
    logic [2:0] next_bpos;
    logic byte_done;
    logic opc_is_prog;
    logic next_is_prog;
    logic buf_wr;
    // Driven by the core side; declared here because the link-side lock synchroniser reads it first.
    logic buf_lock;

    always_comb begin
        cur_b = fresh ? 3'h0 : bpos;
        cur_n = fresh ? 3'h0 : bcnt;
        quad = (cur_n >= flash_seq_pkg::BYTES_ADDR) && (opc == flash_seq_pkg::OPC_QUAD_PAGE); // see R2
        next_sh = quad ? {shreg[3:0], i_data_line} : {shreg[6:0], i_data_line[0]}; // see R7 see R23
        next_bpos = quad ? 3'(cur_b + 3'h4) : 3'(cur_b + 3'h1);
        byte_done = (next_bpos == 3'h0);
        opc_is_prog = (opc == flash_seq_pkg::OPC_PAGE) || (opc == flash_seq_pkg::OPC_FAST_PAGE)
            || (opc == flash_seq_pkg::OPC_QUAD_PAGE);
        next_is_prog = (next_sh == flash_seq_pkg::OPC_PAGE) || (next_sh == flash_seq_pkg::OPC_FAST_PAGE)
            || (next_sh == flash_seq_pkg::OPC_QUAD_PAGE);
        buf_wr = byte_done && (cur_n >= flash_seq_pkg::BYTES_ADDR) && opc_is_prog && !lock_s2;
    end

    // The select pin presets this flag; the first clock edge of a frame clears it.
    always_ff @(posedge i_sclk or posedge i_select_n) begin
        if (i_select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_tog <= 1'b0;
            bpos <= 3'h0;
            bcnt <= 3'h0;
            shreg <= 8'h00;
            opc <= 8'h00;
            addr <= 24'h000000;
            widx <= 8'h00;
        end else begin
            if (fresh) begin
                frame_tog <= ~frame_tog;
            end
            shreg <= next_sh;
            bpos <= next_bpos;
            bcnt <= (byte_done && cur_n != flash_seq_pkg::BYTES_DATA) ? 3'(cur_n + 3'h1) : cur_n;
            if (byte_done && cur_n == 3'h0) begin
                opc <= next_sh;
            end
            if (byte_done && cur_n != 3'h0 && cur_n < flash_seq_pkg::BYTES_ADDR) begin
                addr <= {addr[15:0], next_sh};
            end
            if (byte_done && cur_n == 3'h3) begin
                widx <= next_sh;
            end else if (buf_wr) begin
                widx <= widx + 8'h01; // see R5
            end
        end
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            lock_s1 <= buf_lock;
            lock_s2 <= lock_s1;
        end
    end

    // Later bytes overwrite earlier ones at the same index, so the last 256 win.
    always_ff @(posedge i_sclk) begin
        if (buf_wr) begin
            page_buf[widx] <= next_sh; // see R4
        end
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            keep_mask <= '0;
        end else if (byte_done && cur_n == 3'h0 && next_is_prog && !lock_s2) begin
            keep_mask <= '0; // see R4
        end else if (buf_wr) begin
            keep_mask[widx] <= 1'b1;
        end
    end

    // Core side.
    logic sel_s1;
    logic sel_s2;
    logic sel_d;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic cap_valid;
    flash_seq_pkg::frame_cap_t cap;
    flash_seq_pkg::seq_state_t state;
    flash_seq_pkg::op_kind_t cur_kind;
    flash_seq_pkg::op_kind_t susp_kind;
    logic [31:0] cnt;
    logic [31:0] susp_cnt;
    logic [23:0] cur_addr;
    logic [23:0] susp_addr;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            sel_d <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_seen <= 1'b0;
            cap_valid <= 1'b0;
            cap <= '0;
        end else begin
            sel_s1 <= i_select_n;
            sel_s2 <= sel_s1;
            sel_d <= sel_s2;
            tog_s1 <= frame_tog;
            tog_s2 <= tog_s1;
            // Link registers are frozen once select is high, so they are safe to sample here.
            cap_valid <= sel_s2 && !sel_d && (tog_s2 != tog_seen);
            if (sel_s2 && !sel_d) begin
                tog_seen <= tog_s2;
                cap <= {opc, addr, bcnt, bpos};
            end
        end
    end

    logic cmd_ok;
    logic addr_ok;
    logic data_ok;
    logic prot;
    logic [6:0] prot_blocks;
    logic can_prog;
    logic can_erase;
    logic ev_done;
    logic ev_susp;
    logic ev_res;
    flash_seq_pkg::op_kind_t go_kind;
    logic [31:0] go_cyc;
    logic [23:0] go_addr;

    always_comb begin
        cmd_ok = cap_valid && cap.bytes == flash_seq_pkg::BYTES_CMD && cap.bit_pos == 3'h0; // see R15
        addr_ok = cap_valid && cap.bytes == flash_seq_pkg::BYTES_ADDR && cap.bit_pos == 3'h0; // see R11
        data_ok = cap_valid && cap.bytes == flash_seq_pkg::BYTES_DATA && cap.bit_pos == 3'h0; // see R6
        prot_blocks = (i_protect[2:0] == 3'h0) ? 7'h00 : 7'(7'h01 << (i_protect[2:0] - 3'h1));
        prot = {1'b0, cap.addr[flash_seq_pkg::BLK64_LSB +: 6]}
            >= 7'(flash_seq_pkg::BLK64_COUNT - prot_blocks);
        // No new cycle while busy; a suspended kind admits only the other kind.
        can_prog = !o_status.write_in_progress && (state == flash_seq_pkg::ST_IDLE // see R24
            || (state == flash_seq_pkg::ST_HALT && susp_kind != flash_seq_pkg::K_PAGE)); // see R20
        can_erase = !o_status.write_in_progress && (state == flash_seq_pkg::ST_IDLE
            || (state == flash_seq_pkg::ST_HALT && susp_kind == flash_seq_pkg::K_PAGE)); // see R18
        go_kind = flash_seq_pkg::K_NONE;
        go_cyc = PP_CYC;
        go_addr = cap.addr;
        if (o_status.write_enable_latch) begin // see R3 see R25
            if (data_ok && can_prog && !prot // see R9
                && (cap.opcode == flash_seq_pkg::OPC_PAGE || cap.opcode == flash_seq_pkg::OPC_FAST_PAGE
                || (cap.opcode == flash_seq_pkg::OPC_QUAD_PAGE && i_quad_lines_enable))) begin // see R1
                go_kind = flash_seq_pkg::K_PAGE;
            end else if (addr_ok && can_erase && !prot) begin // see R14
                if (cap.opcode == flash_seq_pkg::OPC_SECTOR) begin
                    go_kind = flash_seq_pkg::K_SECTOR;
                    go_cyc = SE_CYC;
                    go_addr = cap.addr & flash_seq_pkg::SECTOR_MASK; // see R10
                end else if (cap.opcode == flash_seq_pkg::OPC_BLK32) begin
                    go_kind = flash_seq_pkg::K_BLK32;
                    go_cyc = BE_CYC;
                    go_addr = cap.addr & flash_seq_pkg::BLK32_MASK; // see R12
                end else if (cap.opcode == flash_seq_pkg::OPC_BLK64) begin
                    go_kind = flash_seq_pkg::K_BLK64;
                    go_cyc = BE_CYC;
                    go_addr = cap.addr & flash_seq_pkg::BLK64_MASK; // see R13
                end
            end else if (cmd_ok && state == flash_seq_pkg::ST_IDLE && i_protect == 5'h00 // see R16
                && (cap.opcode == flash_seq_pkg::OPC_CHIP_A || cap.opcode == flash_seq_pkg::OPC_CHIP_B)) begin
                go_kind = flash_seq_pkg::K_CHIP;
                go_cyc = CE_CYC;
                go_addr = 24'h000000;
            end
        end
        ev_done = (state == flash_seq_pkg::ST_BUSY) && (cnt == 32'h1);
        ev_susp = (state == flash_seq_pkg::ST_BUSY) && !ev_done && cmd_ok && !o_status.suspend_flag
            && cap.opcode == flash_seq_pkg::OPC_SUSPEND && cur_kind != flash_seq_pkg::K_CHIP; // see R17 see R19
        ev_res = (state == flash_seq_pkg::ST_HALT) && cmd_ok && o_status.suspend_flag && !o_status.write_in_progress
            && cap.opcode == flash_seq_pkg::OPC_RESUME && go_kind == flash_seq_pkg::K_NONE; // see R21
    end

    // Sequencer: the active cycle and the one held by a suspend.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= flash_seq_pkg::ST_IDLE;
            cnt <= 32'h0;
            cur_kind <= flash_seq_pkg::K_NONE;
            cur_addr <= 24'h000000;
            susp_kind <= flash_seq_pkg::K_NONE;
            susp_cnt <= 32'h0;
            susp_addr <= 24'h000000;
            buf_lock <= 1'b0;
        end else begin
            buf_lock <= (state == flash_seq_pkg::ST_BUSY)
                || (o_status.suspend_flag && susp_kind == flash_seq_pkg::K_PAGE);
            unique case (state)
                flash_seq_pkg::ST_IDLE: begin
                    if (go_kind != flash_seq_pkg::K_NONE) begin
                        state <= flash_seq_pkg::ST_BUSY; // see R8
                        cnt <= go_cyc;
                        cur_kind <= go_kind;
                        cur_addr <= go_addr;
                    end
                end
                flash_seq_pkg::ST_BUSY: begin
                    if (ev_done) begin
                        // A cycle run inside a suspend returns to the held one.
                        state <= o_status.suspend_flag ? flash_seq_pkg::ST_HALT : flash_seq_pkg::ST_IDLE;
                        cur_kind <= flash_seq_pkg::K_NONE;
                    end else if (ev_susp) begin
                        state <= flash_seq_pkg::ST_HALT;
                        susp_kind <= cur_kind;
                        susp_cnt <= cnt;
                        susp_addr <= cur_addr;
                        cur_kind <= flash_seq_pkg::K_NONE;
                    end else begin
                        cnt <= cnt - 32'h1;
                    end
                end
                flash_seq_pkg::ST_HALT: begin
                    if (go_kind != flash_seq_pkg::K_NONE) begin
                        state <= flash_seq_pkg::ST_BUSY;
                        cnt <= go_cyc;
                        cur_kind <= go_kind;
                        cur_addr <= go_addr;
                    end else if (ev_res) begin
                        state <= flash_seq_pkg::ST_BUSY; // see R22
                        cnt <= susp_cnt;
                        cur_kind <= susp_kind;
                        cur_addr <= susp_addr;
                        susp_kind <= flash_seq_pkg::K_NONE;
                    end
                end
                default: begin
                    state <= flash_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_status <= flash_seq_pkg::STATUS_RST;
        end else begin
            if (go_kind != flash_seq_pkg::K_NONE || ev_res) begin
                o_status.write_in_progress <= 1'b1; // see R8 see R22
            end else if (ev_done || ev_susp) begin
                o_status.write_in_progress <= 1'b0;
            end
            if (ev_susp) begin
                o_status.suspend_flag <= 1'b1;
            end else if (ev_res) begin
                o_status.suspend_flag <= 1'b0;
            end
            // The latch is cleared as the cycle is launched, well before it ends.
            if (go_kind != flash_seq_pkg::K_NONE) begin
                o_status.write_enable_latch <= 1'b0; // see R8
            end else if (cmd_ok && !o_status.write_in_progress && cap.opcode == flash_seq_pkg::OPC_WR_ENABLE) begin
                o_status.write_enable_latch <= 1'b1;
            end else if (cmd_ok && !o_status.write_in_progress && cap.opcode == flash_seq_pkg::OPC_WR_DISABLE) begin
                o_status.write_enable_latch <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mem_cmd <= '0;
            o_pgm_byte <= '0;
        end else begin
            o_mem_cmd.start <= (go_kind != flash_seq_pkg::K_NONE);
            o_mem_cmd.halt <= ev_susp;
            o_mem_cmd.resume <= ev_res;
            o_mem_cmd.done <= ev_done;
            if (go_kind != flash_seq_pkg::K_NONE) begin
                o_mem_cmd.kind <= go_kind;
                o_mem_cmd.addr <= go_addr;
            end else if (ev_res) begin
                o_mem_cmd.kind <= susp_kind;
                o_mem_cmd.addr <= susp_addr;
            end
            // The buffer is read on every clock, whether or not the link is locked against program frames.
            o_pgm_byte.data <= page_buf[i_pgm_index];
            o_pgm_byte.keep <= keep_mask[i_pgm_index]; // see R4
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);

    property p_wel_needed;
        o_mem_cmd.start |-> $past(o_status.write_enable_latch, 1) && !o_status.write_enable_latch;
    endproperty
    a_wel_needed: assert property (p_wel_needed) else $error("cycle started without latch"); // see R3

    property p_wip_hold;
        o_mem_cmd.start |-> o_status.write_in_progress [*4];
    endproperty
    a_wip_hold: assert property (p_wip_hold) else $error("busy flag not held"); // see R8

    property p_page_frame;
        o_mem_cmd.start && o_mem_cmd.kind == flash_seq_pkg::K_PAGE
            |-> cap.bit_pos == 3'h0 && cap.bytes == flash_seq_pkg::BYTES_DATA;
    endproperty
    a_page_frame: assert property (p_page_frame) else $error("program on bad frame"); // see R6

    property p_erase_frame;
        o_mem_cmd.start && (o_mem_cmd.kind == flash_seq_pkg::K_SECTOR || o_mem_cmd.kind == flash_seq_pkg::K_BLK64
            || o_mem_cmd.kind == flash_seq_pkg::K_BLK32)
            |-> cap.bytes == flash_seq_pkg::BYTES_ADDR && cap.bit_pos == 3'h0;
    endproperty
    a_erase_frame: assert property (p_erase_frame) else $error("erase on bad frame"); // see R11

    property p_quad_enable;
        o_mem_cmd.start && cap.opcode == flash_seq_pkg::OPC_QUAD_PAGE |-> $past(i_quad_lines_enable);
    endproperty
    a_quad_enable: assert property (p_quad_enable) else $error("quad program while disabled"); // see R1

    property p_chip_prot;
        o_mem_cmd.start && o_mem_cmd.kind == flash_seq_pkg::K_CHIP |-> $past(i_protect) == 5'h00;
    endproperty
    a_chip_prot: assert property (p_chip_prot) else $error("chip erase while protected"); // see R16

    property p_no_chip_susp;
        $rose(o_status.suspend_flag) |-> o_mem_cmd.halt && $past(cur_kind) != flash_seq_pkg::K_CHIP;
    endproperty
    a_no_chip_susp: assert property (p_no_chip_susp) else $error("chip erase suspended"); // see R19

    property p_resume_busy;
        $fell(o_status.suspend_flag) |-> ##[0:8] o_status.write_in_progress;
    endproperty
    a_resume_busy: assert property (p_resume_busy) else $error("resume not busy in time"); // see R22

    property p_busy_reject;
        o_mem_cmd.start |-> !$past(o_status.write_in_progress, 1);
    endproperty
    a_busy_reject: assert property (p_busy_reject) else $error("cycle started while busy"); // see R24
endmodule : nor_program_erase_sequencer

// File: nor_program_erase_sequencer_tb.sv
// Self-checking bench for the program and erase sequencer.
`timescale 1ns/100ps
module nor_program_erase_sequencer_tb;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_quad_lines_enable = 1'b0;
    logic [4:0] i_protect = 5'h00;
    logic [7:0] i_pgm_index = 8'h00;
    logic i_sclk;
    logic i_select_n;
    logic [3:0] i_data_line;
    flash_seq_pkg::flash_status_t o_status;
    flash_seq_pkg::mem_cmd_t o_mem_cmd;
    flash_seq_pkg::pgm_byte_t o_pgm_byte;
    flash_seq_pkg::mem_cmd_t last;
    int errors = 0;
    int checks_done = 0;
    logic [23:0] a;
    logic [7:0] d[$];
    logic [7:0] ops[3] = '{8'h20, 8'h52, 8'hd8};
    always #12.5 i_mclk = ~i_mclk;
    spi_host_model host (.o_select_n(i_select_n), .o_sclk(i_sclk), .o_data_line(i_data_line));
    nor_program_erase_sequencer #(.PROGRAM_CYCLE_TIME_US(1), .SECTOR_ERASE_TIME_US(2),
        .BLOCK_ERASE_TIME_US(1), .CHIP_ERASE_TIME_US(2)) dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_sclk(i_sclk), .i_select_n(i_select_n), .i_data_line(i_data_line),
        .i_quad_lines_enable(i_quad_lines_enable), .i_protect(i_protect), .i_pgm_index(i_pgm_index),
        .o_status(o_status), .o_mem_cmd(o_mem_cmd), .o_pgm_byte(o_pgm_byte));
    always @(posedge i_mclk) if (o_mem_cmd.start === 1'b1) last <= o_mem_cmd;
    int n_halt = 0;
    int n_res = 0;
    int n_done = 0;
    always @(posedge i_mclk) begin
        if (o_mem_cmd.halt === 1'b1) n_halt <= n_halt + 1;
        if (o_mem_cmd.resume === 1'b1) n_res <= n_res + 1;
        if (o_mem_cmd.done === 1'b1) n_done <= n_done + 1;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk
    function automatic logic [23:0] align(input logic [7:0] op, input logic [23:0] x);
        return op == 8'h20 ? x & 24'hfff000 : op == 8'h52 ? x & 24'hff8000 : x & 24'hff0000;
    endfunction : align
    // Status is read eight edges after the frame, past the four-edge decode latency.
    task automatic run(input logic [7:0] b[$], input logic exp, input bit quad = 1'b0, input int extra = 0);
        @(posedge i_mclk);
        #1;
        host.send(b, quad, extra);
        repeat (8) @(posedge i_mclk);
        #1;
        chk("wip", exp, o_status.write_in_progress);
    endtask : run
    task automatic wel_on();
        run({8'h06}, 1'b0);
        chk("wel", 1, o_status.write_enable_latch);
    endtask : wel_on
    task automatic idle();
        for (int n = 0; n < 3000 && o_status.write_in_progress !== 1'b0; n++) @(posedge i_mclk);
        chk("idle", 0, o_status.write_in_progress);
    endtask : idle
    task automatic rd(input logic [7:0] idx, input logic keep, input logic [7:0] data);
        @(posedge i_mclk);
        #1 i_pgm_index = idx;
        @(posedge i_mclk);
        #1;
        chk("keep", keep, o_pgm_byte.keep);
        if (keep) chk("data", data, o_pgm_byte.data);
    endtask : rd
    initial begin
        #1000000;
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h1498));
        repeat (12) @(posedge i_mclk);
        #1 i_arst_n = 1'b1;
        a = $urandom;
        run({8'h20, a[23:16], a[15:8], a[7:0]}, 0);
        chk("wel", 0, o_status.write_enable_latch);
        foreach (ops[i]) begin
            a = $urandom;
            wel_on();
            run({ops[i], a[23:16], a[15:8], a[7:0]}, 1);
            chk("wel", 0, o_status.write_enable_latch);
            chk("kind", i + 2, last.kind);
            chk("addr", align(ops[i], a), last.addr);
            idle();
        end
        for (int i = 0; i < 2; i++) begin
            wel_on();
            run({i ? 8'h60 : 8'hc7}, 1);
            chk("kind", 5, last.kind);
            idle();
        end
        wel_on();
        run({8'h52, a[23:16], a[15:8], a[7:0]}, 0, 0, 1);
        run({8'h20, a[23:16], a[15:8]}, 0);
        @(posedge i_mclk);
        #1 i_protect = 5'h01;
        run({8'h20, 8'h3f, 8'h12, 8'h34}, 0);
        run({8'h02, 8'h3f, 8'h00, 8'h00, 8'ha5}, 0);
        run({8'hc7}, 0);
        @(posedge i_mclk);
        #1 i_protect = 5'h08;
        run({8'h60}, 0);
        @(posedge i_mclk);
        #1 i_protect = 5'h00;
        d = {8'h32, a[23:16], a[15:8], 8'hfe, 8'($urandom), 8'($urandom), 8'($urandom)};
        run(d, 0, 1);
        @(posedge i_mclk);
        #1 i_quad_lines_enable = 1'b1;
        run(d, 1, 1);
        chk("addr", {a[23:8], 8'hfe}, last.addr);
        idle();
        for (int i = 0; i < 3; i++) rd(8'(8'hfe + i), 1'b1, d[4 + i]);
        rd(8'h01, 0, 8'h00);
        wel_on();
        d = {8'h02, a[23:16], a[15:8], 8'h00};
        repeat (257) d.push_back(8'($urandom));
        run(d, 1);
        idle();
        rd(8'h00, 1, d[260]);
        rd(8'h01, 1, d[5]);
        wel_on();
        run({8'hf2, a[23:16], a[15:8], 8'h10, 8'h3c}, 1);
        idle();
        rd(8'h10, 1, 8'h3c);
        rd(8'h11, 0, 8'h00);
        wel_on();
        run({8'h20, a[23:16], a[15:8], a[7:0]}, 1);
        run({8'h75}, 0);
        chk("sus", 1, o_status.suspend_flag);
        wel_on();
        run({8'h20, a[23:16], a[15:8], a[7:0]}, 0);
        run({8'h7a}, 1);
        chk("sus", 0, o_status.suspend_flag);
        idle();
        run({8'h7a}, 0);
        wel_on();
        run({8'hc7}, 1);
        run({8'h75}, 1);
        chk("sus", 0, o_status.suspend_flag);
        idle();
        repeat (2) @(posedge i_mclk);
        #1;
        chk("halt", 1, n_halt);
        chk("resume", 1, n_res);
        chk("done", 10, n_done);
        print_verdict();
    end
endmodule : nor_program_erase_sequencer_tb

// File: spi_host_model.sv
// Host-side model that frames commands onto the serial link.
`timescale 1ns/100ps
module spi_host_model (
    output logic o_select_n,
    output logic o_sclk,
    output logic [3:0] o_data_line
);
    initial begin
        o_select_n = 1'b1;
        o_sclk = 1'b0;
        o_data_line = 4'h5;
    end
    // Bytes go MSB first; past the address they use all four lines when quad is set.
    // Lines not carrying a bit show a changing pattern so that no stale value can be relied on.
    task automatic send(input logic [7:0] b[$], input bit quad, input int extra);
        int step;
        o_select_n = 1'b0;
        #6;
        for (int i = 0; i < b.size(); i++) begin
            step = (quad && i > 3) ? 4 : 1;
            for (int k = 7; k >= 0; k -= step) begin
                o_data_line = (step == 4) ? b[i][k -: 4] : {~o_data_line[3:1], b[i][k]};
                #6 o_sclk = 1'b1;
                #6 o_sclk = 1'b0;
            end
        end
        repeat (extra) begin
            o_data_line = ~o_data_line;
            #6 o_sclk = 1'b1;
            #6 o_sclk = 1'b0;
        end
        o_select_n = 1'b1;
        o_data_line = ~o_data_line;
    endtask : send
endmodule : spi_host_model
